// ### msx_regs.svh
`ifndef MSX_REGS_SVH
`define MSX_REGS_SVH

// register byte offsets
`define MSX_A_CTRL     12'h000
`define MSX_A_FP_CONTROL_STATUS     12'h004
`define MSX_A_OPA      12'h008
`define MSX_A_OPB      12'h00c
`define MSX_A_CMD      12'h010
`define MSX_A_ACC_HI   12'h014
`define MSX_A_ACC_LO   12'h018
`define MSX_A_STATUS   12'h01c
`define MSX_A_FIR      12'h020
`define MSX_A_SEL      12'h024
`define MSX_A_FPR_LO   12'h028
`define MSX_A_FPR_HI   12'h02c
`define MSX_A_CP2_LO   12'h030
`define MSX_A_CP2_HI   12'h034
`define MSX_A_CP0      12'h038

// control, status and command fields
`define MSX_CTRL_FR    3
`define MSX_ST_CU      0
`define MSX_ST_RI      1
`define MSX_ST_TRAP    2
`define MSX_CMD_FMT    4
`define MSX_CMD_FD     6
`define MSX_CMD_FS     11
`define MSX_CMD_FT     16
`define MSX_CMD_FR     21
`define MSX_CMD_SEL    26

// fp control/status fields
`define MSX_FP_CONTROL_STATUS_FLAG  2
`define MSX_FP_CONTROL_STATUS_EN    7
`define MSX_FP_CONTROL_STATUS_CAUSE 12
`define MSX_FP_CONTROL_STATUS_MAC   20
`define MSX_FP_CONTROL_STATUS_MASK  21'h13ffff

// cause bit positions
`define MSX_C_I        0
`define MSX_C_U        1
`define MSX_C_O        2
`define MSX_C_V        4
`define MSX_C_E        5

// number formats; the bias doubles as the largest exponent
`define MSX_D_BIAS     14'sh3ff
`define MSX_S_BIAS     14'sh07f
`define MSX_D_EMIN     (-14'sh3fe)
`define MSX_S_EMIN     (-14'sh07e)
`define MSX_ZERO_EXP   (-14'sh7d0)
`define MSX_L_D        7'h38
`define MSX_L_S        7'h55
`define MSX_QNAN_D     64'h7ff8000000000000
`define MSX_QNAN_S     32'h7fc00000

`endif

// ### msx_pkg.sv
`include "msx_regs.svh"

package msx_pkg;

  typedef enum logic [3:0] {
    MSX_OP_NOP    = 4'h0,
    MSX_OP_FMSUB  = 4'h1,
    MSX_OP_UNSIGNED_ACC_MUL_SUB  = 4'h2,
    MSX_OP_SYSCTL = 4'h3,
    MSX_OP_FP_LO  = 4'h4,
    MSX_OP_COP_LO = 4'h5,
    MSX_OP_FP_HI  = 4'h6,
    MSX_OP_COP_HI = 4'h7,
    MSX_OP_ACC_HI = 4'h8
  } msx_op_t;

  typedef enum logic [1:0] {MSX_FMT_S = 2'h0, MSX_FMT_D = 2'h1, MSX_FMT_PS = 2'h2} msx_fmt_t;
  typedef enum logic [1:0] {MSX_RN = 2'h0, MSX_RZ = 2'h1, MSX_RP = 2'h2, MSX_RM = 2'h3} msx_rm_t;
  typedef enum logic [1:0] {MSX_ZERO = 2'h0, MSX_NORM = 2'h1, MSX_INF = 2'h2, MSX_NAN = 2'h3} msx_cls_t;
  typedef enum logic [1:0] {MSX_K_ZERO = 2'h0, MSX_K_INF = 2'h1, MSX_K_MAX = 2'h2, MSX_K_NAN = 2'h3} msx_kind_t;

  typedef struct packed {
    logic               s;
    msx_cls_t           cls;
    logic               dn;
    logic               sn;
    logic signed [13:0] e;
    logic [52:0]        m;
  } msx_unp_t;

  typedef struct packed {
    logic signed [13:0] e;
    logic [52:0]        m;
    logic               inx;
  } msx_rnd_t;

  typedef struct packed {
    logic [63:0] val;
    logic [5:0]  cause;
  } msx_fres_t;

  typedef struct packed {
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [3:0]         ctrl;
    logic [20:0]        fp_control_status;
    logic [31:0]        opa;
    logic [31:0]        opb;
    logic [31:0]        cmd;
    logic [31:0]        acc_hi;
    logic [31:0]        acc_lo;
    logic [2:0]         status;
    logic [7:0]         sel;
    logic [31:0][63:0]  fp_reg;
    logic [31:0][63:0]  cp2;
    logic [255:0][31:0] cp0;
  } msx_state_t;

endpackage

// ### msx_exec.sv
// Behaviour
// - unfused mode rounds the product with the current rounding mode before subtracting
// - fused mode keeps the product exact, with no intermediate rounding
// - subtract third operand exactly, round once, store result in destination
// - unfused results and flags equal separate multiply then subtract
// - fused multiply step may raise only invalid operation
// - paired single halves computed independently, their conditions ORed
// - without a trap, cause bits are ORed into sticky flag bits
// - report inexact, unimplemented, invalid, overflow and underflow
// - unsigned 32x32 product subtracted from the 64-bit accumulator pair
// - difference high word to acc_high, low word to acc_low, no general_reg
// - accumulate-subtract never raises an arithmetic exception
// - sysctl move writes source into register picked by number and select
// - low fp move puts source bits 31..0 into fp_reg low word
// - low cop move passes source word to register named by impl field
// - high fp move writes bits 63..32 and keeps bits 31..0
// - high cop move writes bits 63..32 and keeps low 32 bits
// - acc_high move loads the source word into acc_high
`timescale 1ns/100ps
`include "msx_regs.svh"

module msx_exec #(
  parameter int unsigned HAS_FUSED = 1,
  parameter int unsigned HAS_COP2  = 1
) (
  input  wire logic        pclk,    // bus clock
  input  wire logic        presetn, // async reset, low active
  input  wire logic        clk_en,  // freezes all state when low
  input  wire logic        psel,    // apb select
  input  wire logic        penable, // apb access phase
  input  wire logic        pwrite,  // apb write
  input  wire logic [11:0] paddr,   // apb byte address
  input  wire logic [31:0] pwdata,  // apb write data
  output logic      [31:0] prdata,  // apb read data
  output logic             pready,  // apb ready
  output logic             pslverr  // apb error on unmapped address
);

  ////////////////////////////////////////////////////////////////////////////
  if ((HAS_FUSED > 1) || (HAS_COP2 > 1)) begin : g_bad_param
    $error("msx_exec: HAS_FUSED and HAS_COP2 must be 0 or 1");
  end

  msx_pkg::msx_state_t q;
  msx_pkg::msx_state_t n;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] fp_special(input logic s, input logic dbl,
                                             input msx_pkg::msx_kind_t k);
    logic [63:0] v;
    case (k)
      msx_pkg::MSX_K_ZERO: v = dbl ? {s, 63'h0} : {32'h0, s, 31'h0};
      msx_pkg::MSX_K_INF:  v = dbl ? {s, 11'h7ff, 52'h0} : {32'h0, s, 8'hff, 23'h0};
      msx_pkg::MSX_K_MAX:  v = dbl ? {s, 11'h7fe, {52{1'b1}}} : {32'h0, s, 8'hfe, 23'h7fffff};
      default:             v = dbl ? `MSX_QNAN_D : {32'h0, `MSX_QNAN_S};
    endcase
    return v;
  endfunction

  function automatic msx_pkg::msx_unp_t fp_unpack(input logic [63:0] x, input logic dbl);
    logic [10:0]       be;
    logic [51:0]       f;
    msx_pkg::msx_unp_t u;
    be = dbl ? x[62:52] : {3'h0, x[30:23]};
    f = dbl ? x[51:0] : {x[22:0], 29'h0};
    u.s = dbl ? x[63] : x[31];
    u.e = $signed({3'h0, be}) - (dbl ? `MSX_D_BIAS : `MSX_S_BIAS);
    u.m = {1'b1, f};
    u.dn = (be == 11'h0) && (f != 52'h0);
    u.sn = ~f[51];
    if (be == 11'h0) begin
      // zero sits far below any real exponent so alignment shifts it out
      u.cls = msx_pkg::MSX_ZERO;
      u.e = `MSX_ZERO_EXP;
      u.m = 53'h0;
    end else if (be == (dbl ? 11'h7ff : 11'h0ff)) begin
      u.cls = (f == 52'h0) ? msx_pkg::MSX_INF : msx_pkg::MSX_NAN;
    end else begin
      u.cls = msx_pkg::MSX_NORM;
    end
    return u;
  endfunction

  function automatic logic [108:0] shr_sticky(input logic [108:0] x, input logic signed [13:0] sh);
    logic [108:0] lost;
    lost = x & ~({109{1'b1}} << sh[6:0]);
    if (sh >= 14'sh06d) begin
      return {108'h0, |x};
    end
    return (x >> sh[6:0]) | {108'h0, |lost};
  endfunction

  // field value is f * 2^(e-106); result mantissa has its point at bit 52
  function automatic msx_pkg::msx_rnd_t fp_round(input logic s, input logic signed [13:0] e,
                                                 input logic [108:0] f, input logic dbl,
                                                 input logic [1:0] rm);
    logic [108:0]      nf;
    logic [108:0]      ulp;
    logic [108:0]      tr;
    logic [109:0]      sum;
    logic [6:0]        k;
    logic              g;
    logic              st;
    logic              inc;
    msx_pkg::msx_rnd_t r;
    k = 7'h0;
    for (int i = 0; i < 109; i++) begin
      if (f[i]) k = 7'(i);
    end
    nf = f << (7'h6c - k);
    ulp = 109'h1 << (dbl ? `MSX_L_D : `MSX_L_S);
    tr = nf & ~(ulp - 109'h1);
    g = |(nf & (ulp >> 1));
    st = |(nf & ((ulp >> 1) - 109'h1));
    case (rm)
      msx_pkg::MSX_RN: inc = g & (st | |(nf & ulp));
      msx_pkg::MSX_RP: inc = ~s & (g | st);
      msx_pkg::MSX_RM: inc = s & (g | st);
      default:         inc = 1'b0;
    endcase
    sum = {1'b0, tr} + (inc ? {1'b0, ulp} : 110'h0);
    r.e = e + $signed({7'h0, k}) - 14'sh06a + $signed({13'h0, sum[109]});
    r.m = sum[109] ? sum[109:57] : sum[108:56];
    r.inx = g | st;
    return r;
  endfunction

  // subnormal results are not produced: they raise unimplemented operation
  function automatic msx_pkg::msx_fres_t fp_pack(input logic s, input msx_pkg::msx_rnd_t r,
                                                 input logic dbl, input logic [1:0] rm);
    msx_pkg::msx_fres_t o;
    logic               big;
    o.cause = {5'h0, r.inx};
    o.val = dbl ? {s, 11'(r.e + `MSX_D_BIAS), r.m[51:0]}
                : {32'h0, s, 8'(r.e + `MSX_S_BIAS), r.m[51:29]};
    big = (rm == msx_pkg::MSX_RZ) || ((rm == msx_pkg::MSX_RP) && s) ||
          ((rm == msx_pkg::MSX_RM) && !s);
    if (r.e > (dbl ? `MSX_D_BIAS : `MSX_S_BIAS)) begin
      o.cause = 6'h05;
      o.val = fp_special(s, dbl, big ? msx_pkg::MSX_K_MAX : msx_pkg::MSX_K_INF);
    end else if (r.e < (dbl ? `MSX_D_EMIN : `MSX_S_EMIN)) begin
      o.cause = 6'h22;
      o.val = fp_special(s, dbl, msx_pkg::MSX_K_ZERO);
    end
    return o;
  endfunction

  function automatic msx_pkg::msx_fres_t fp_msub(input logic [63:0] xs, input logic [63:0] xt,
                                                 input logic [63:0] xr, input logic dbl,
                                                 input logic fused, input logic [1:0] rm);
    msx_pkg::msx_unp_t  a;
    msx_pkg::msx_unp_t  b;
    msx_pkg::msx_unp_t  c;
    msx_pkg::msx_rnd_t  p;
    msx_pkg::msx_fres_t o;
    logic [105:0]       pm;
    logic [108:0]       pf;
    logic [108:0]       cf;
    logic [108:0]       rf;
    logic signed [13:0] ep;
    logic signed [13:0] e;
    logic               sp;
    logic               sc;
    logic               rs;
    logic [5:0]         pc;
    a = fp_unpack(xs, dbl);
    b = fp_unpack(xt, dbl);
    c = fp_unpack(xr, dbl);
    sp = a.s ^ b.s;
    sc = ~c.s;
    pc = 6'h0;
    o.cause = 6'h0;
    o.val = fp_special(1'b0, dbl, msx_pkg::MSX_K_NAN);
    if (a.dn || b.dn || c.dn) begin
      o.cause[`MSX_C_E] = 1'b1;
      return o;
    end
    if ((a.cls == msx_pkg::MSX_NAN) || (b.cls == msx_pkg::MSX_NAN) ||
        (c.cls == msx_pkg::MSX_NAN)) begin
      o.cause[`MSX_C_V] = ((a.cls == msx_pkg::MSX_NAN) && a.sn) ||
                          ((b.cls == msx_pkg::MSX_NAN) && b.sn) ||
                          ((c.cls == msx_pkg::MSX_NAN) && c.sn);
      return o;
    end
    // in fused mode invalid is the only condition the multiply step can raise here
    if (((a.cls == msx_pkg::MSX_INF) && (b.cls == msx_pkg::MSX_ZERO)) ||
        ((a.cls == msx_pkg::MSX_ZERO) && (b.cls == msx_pkg::MSX_INF))) begin
      o.cause[`MSX_C_V] = 1'b1;
      return o;
    end
    if ((a.cls == msx_pkg::MSX_INF) || (b.cls == msx_pkg::MSX_INF)) begin
      if ((c.cls == msx_pkg::MSX_INF) && (sp != sc)) begin
        o.cause[`MSX_C_V] = 1'b1;
      end else begin
        o.val = fp_special(sp, dbl, msx_pkg::MSX_K_INF);
      end
      return o;
    end
    if (c.cls == msx_pkg::MSX_INF) begin
      o.val = fp_special(sc, dbl, msx_pkg::MSX_K_INF);
      return o;
    end
    pm = a.m * b.m;
    ep = (pm == 106'h0) ? `MSX_ZERO_EXP : a.e + b.e;
    if (!fused && (pm != 106'h0)) begin
      // product rounded alone, as a lone multiply would
      p = fp_round(sp, ep, {1'b0, pm, 2'h0}, dbl, rm);
      o = fp_pack(sp, p, dbl, rm);
      if (o.cause[`MSX_C_O] || o.cause[`MSX_C_E]) begin
        return o;
      end
      pc = o.cause;
      pm = {1'b0, p.m, 52'h0};
      ep = p.e;
    end
    pf = {1'b0, pm, 2'h0};
    cf = {2'h0, c.m, 54'h0};
    // sticky keeps the shifted-out tail exact enough for one rounding
    if (ep >= c.e) begin
      cf = shr_sticky(cf, ep - c.e);
      e = ep;
    end else begin
      pf = shr_sticky(pf, c.e - ep);
      e = c.e;
    end
    if (sp == sc) begin
      rf = pf + cf;
      rs = sp;
    end else if (pf >= cf) begin
      rf = pf - cf;
      rs = sp;
    end else begin
      rf = cf - pf;
      rs = sc;
    end
    if (rf == 109'h0) begin
      o.val = fp_special((sp == sc) ? sp : (rm == msx_pkg::MSX_RM), dbl, msx_pkg::MSX_K_ZERO);
      o.cause = pc;
      return o;
    end
    o = fp_pack(rs, fp_round(rs, e, rf, dbl, rm), dbl, rm);
    o.cause = o.cause | pc;
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  msx_pkg::msx_op_t   op;
  msx_pkg::msx_fres_t lo;
  msx_pkg::msx_fres_t hi;
  msx_pkg::msx_fres_t fres;
  logic [1:0]         fmt;
  logic [4:0]         fd;
  logic [4:0]         fs;
  logic [4:0]         ft;
  logic [4:0]         fr;
  logic [2:0]         sel3;
  logic               fused;
  logic               ri;
  logic               cu;
  logic               trap;
  logic               hit;
  logic [31:0]        rdata;

  always_comb begin
    n = q;
    op = msx_pkg::msx_op_t'(pwdata[3:0]);
    fmt = pwdata[`MSX_CMD_FMT +: 2];
    fd = pwdata[`MSX_CMD_FD +: 5];
    fs = pwdata[`MSX_CMD_FS +: 5];
    ft = pwdata[`MSX_CMD_FT +: 5];
    fr = pwdata[`MSX_CMD_FR +: 5];
    sel3 = pwdata[`MSX_CMD_SEL +: 3];
    fused = (HAS_FUSED != 0) && q.fp_control_status[`MSX_FP_CONTROL_STATUS_MAC];
    // low call also serves the low half of a pair
    lo = fp_msub(q.fp_reg[fs], q.fp_reg[ft], q.fp_reg[fr], fmt == msx_pkg::MSX_FMT_D, fused,
                 q.fp_control_status[1:0]);
    hi = fp_msub({32'h0, q.fp_reg[fs][63:32]}, {32'h0, q.fp_reg[ft][63:32]},
                 {32'h0, q.fp_reg[fr][63:32]}, 1'b0, fused, q.fp_control_status[1:0]);
    fres = lo;
    if (fmt == msx_pkg::MSX_FMT_PS) begin
      fres.val = {hi.val[31:0], lo.val[31:0]};
      fres.cause = lo.cause | hi.cause;
    end
    trap = (|(fres.cause[4:0] & q.fp_control_status[`MSX_FP_CONTROL_STATUS_EN +: 5])) || fres.cause[`MSX_C_E];
    ri = 1'b0;
    cu = 1'b0;
    case (op)
      msx_pkg::MSX_OP_FMSUB: begin
        cu = ~q.ctrl[1];
        ri = (fmt == 2'h3) || ((fmt == msx_pkg::MSX_FMT_PS) && !q.ctrl[`MSX_CTRL_FR]);
      end
      msx_pkg::MSX_OP_SYSCTL: cu = ~q.ctrl[0];
      msx_pkg::MSX_OP_FP_LO, msx_pkg::MSX_OP_FP_HI: cu = ~q.ctrl[1];
      msx_pkg::MSX_OP_COP_LO, msx_pkg::MSX_OP_COP_HI: begin
        ri = (HAS_COP2 == 0);
        cu = ~q.ctrl[2];
      end
      msx_pkg::MSX_OP_UNSIGNED_ACC_MUL_SUB, msx_pkg::MSX_OP_ACC_HI, msx_pkg::MSX_OP_NOP: ri = 1'b0;
      default: ri = 1'b1;
    endcase
    rdata = 32'h0;
    hit = 1'b1;
    case (paddr)
      `MSX_A_CTRL:   rdata = {28'h0, q.ctrl};
      `MSX_A_FP_CONTROL_STATUS:   rdata = {11'h0, q.fp_control_status};
      `MSX_A_OPA:    rdata = q.opa;
      `MSX_A_OPB:    rdata = q.opb;
      `MSX_A_CMD:    rdata = q.cmd;
      `MSX_A_ACC_HI: rdata = q.acc_hi;
      `MSX_A_ACC_LO: rdata = q.acc_lo;
      `MSX_A_STATUS: rdata = {29'h0, q.status};
      `MSX_A_FIR:    rdata = {31'h0, HAS_FUSED != 0};
      `MSX_A_SEL:    rdata = {24'h0, q.sel};
      `MSX_A_FPR_LO: rdata = q.fp_reg[q.sel[4:0]][31:0];
      `MSX_A_FPR_HI: rdata = q.fp_reg[q.sel[4:0]][63:32];
      `MSX_A_CP2_LO: rdata = q.cp2[q.sel[4:0]][31:0];
      `MSX_A_CP2_HI: rdata = q.cp2[q.sel[4:0]][63:32];
      `MSX_A_CP0:    rdata = q.cp0[q.sel];
      default:       hit = 1'b0;
    endcase
    // answer registered in setup, so every access phase completes at once
    n.pready = psel & ~penable;
    n.pslverr = 1'b0;
    if (psel && !penable) begin
      n.prdata = rdata;
      n.pslverr = ~hit;
    end
    if (psel && penable && q.pready && pwrite && !q.pslverr) begin
      case (paddr)
        `MSX_A_CTRL:   n.ctrl = pwdata[3:0];
        `MSX_A_FP_CONTROL_STATUS:   n.fp_control_status = pwdata[20:0] & `MSX_FP_CONTROL_STATUS_MASK;
        `MSX_A_OPA:    n.opa = pwdata;
        `MSX_A_OPB:    n.opb = pwdata;
        `MSX_A_ACC_LO: n.acc_lo = pwdata;
        `MSX_A_SEL:    n.sel = pwdata[7:0];
        `MSX_A_CMD: begin
          n.cmd = pwdata;
          n.status = {1'b0, ri, cu & ~ri};
          if (!ri && !cu) begin
            case (op)
              msx_pkg::MSX_OP_FMSUB: begin
                n.fp_control_status[`MSX_FP_CONTROL_STATUS_CAUSE +: 6] = fres.cause;
                if (trap) begin
                  n.status[`MSX_ST_TRAP] = 1'b1;
                end else begin
                  n.fp_control_status[`MSX_FP_CONTROL_STATUS_FLAG +: 5] = q.fp_control_status[`MSX_FP_CONTROL_STATUS_FLAG +: 5] |
                                                fres.cause[4:0];
                  n.fp_reg[fd] = fres.val;
                end
              end
              msx_pkg::MSX_OP_UNSIGNED_ACC_MUL_SUB: begin
                // no flag or status path exists for this one
                {n.acc_hi, n.acc_lo} = {q.acc_hi, q.acc_lo} -
                                       ({32'h0, q.opa} * {32'h0, q.opb});
              end
              msx_pkg::MSX_OP_SYSCTL: n.cp0[{sel3, fs}] = q.opa;
              msx_pkg::MSX_OP_FP_LO:  n.fp_reg[fs][31:0] = q.opa;
              msx_pkg::MSX_OP_FP_HI:  n.fp_reg[fs][63:32] = q.opa;
              msx_pkg::MSX_OP_COP_LO: n.cp2[fs][31:0] = q.opa;
              msx_pkg::MSX_OP_COP_HI: n.cp2[fs][63:32] = q.opa;
              msx_pkg::MSX_OP_ACC_HI: n.acc_hi = q.opa;
              default: n.cmd = pwdata;
            endcase
          end
        end
        default: n.cmd = q.cmd;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;

endmodule

// ### msx_exec_props.sv
`timescale 1ns/100ps
module msx_exec_props (
  input wire logic        pclk,    // bus clock
  input wire logic        presetn, // async reset, low active
  input wire logic        clk_en,  // clock enable
  input wire logic        psel,    // apb select
  input wire logic        penable, // apb access phase
  input wire logic        pwrite,  // apb write
  input wire logic [11:0] paddr,   // apb byte address
  input wire logic [31:0] pwdata,  // apb write data
  input wire logic [31:0] prdata,  // apb read data
  input wire logic        pready,  // apb ready
  input wire logic        pslverr  // apb error
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////
  logic mapped;
  assign mapped = (paddr <= 12'h038) && (paddr[1:0] == 2'h0);
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_bad;
    s_setup ##0 !mapped;
  endsequence
  sequence s_good;
    s_setup ##0 mapped;
  endsequence
  //////////////////////////////
  property p_answer;
    s_setup |=> pready;
  endproperty
  property p_no_spurious;
    pready && $past(clk_en) |-> $past(psel && !penable);
  endproperty
  property p_one_cycle;
    pready && clk_en |=> !pready;
  endproperty
  property p_err_map;
    s_bad |=> pready && pslverr;
  endproperty
  property p_ok_map;
    s_good |=> pready && !pslverr;
  endproperty
  property p_err_zero;
    pslverr |-> prdata == 32'h0;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  // read data only moves at a setup edge
  property p_hold;
    !(psel && !penable) && clk_en |=> $stable(prdata);
  endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  a_no_spurious: assert property (p_no_spurious) else $error("ready without setup");
  a_one_cycle: assert property (p_one_cycle) else $error("ready longer than one cycle");
  a_err_map: assert property (p_err_map) else $error("unmapped address not refused");
  a_ok_map: assert property (p_ok_map) else $error("mapped address refused");
  a_err_zero: assert property (p_err_zero) else $error("read data not zero on error");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_hold: assert property (p_hold) else $error("read data changed outside setup");
endmodule

// ### msx_host.sv
`timescale 1ns/100ps
module msx_host (
  input  wire logic        pclk,    // bus clock
  input  wire logic        pready,  // slave ready
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic      [11:0] paddr,   // byte address
  output logic      [31:0] pwdata   // write data
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hfff;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    // released lines show no stale value
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/100ps
`include "msx_regs.svh"
module testbench;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr;
  logic [33:0] exp_q[$];
  int          n_mismatch, samples_checked;
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  msx_exec u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  msx_host u_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  //////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
    exp_q.push_back({1'b0, err, 32'h0});
    u_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({1'b1, err, e});
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [1:0] fmt, input logic [4:0] fd, fs,
                     ft, fr, input logic [2:0] sel, input logic [31:0] src);
    wr(`MSX_A_OPA, src);
    wr(`MSX_A_CMD, {3'h0, sel, fr, ft, fs, fd, fmt, op});
  endtask
  task automatic mv(input logic [3:0] op, input logic [4:0] idx, input logic [31:0] src);
    cmd(op, 2'h0, 5'h0, idx, 5'h0, 5'h0, 3'h0, src);
  endtask
  task automatic ld(input logic [4:0] idx, input logic [31:0] lo, hi);
    mv(4'h4, idx, lo);
    mv(4'h6, idx, hi);
  endtask
  task automatic finish_test();
    // a note left in the queue means an answer never came
    if (exp_q.size() != 0) begin
      n_mismatch++;
    end
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  //////////////////////////////
  always @(posedge pclk) begin
    logic [33:0] e;
    if (presetn && psel && penable && pready) begin
      e = exp_q.pop_front();
      samples_checked++;
      if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
        n_mismatch++;
        $display("[ERR] %0t got %h/%h exp %h/%h", $time, pslverr, prdata, e[32], e[31:0]);
      end
    end
  end
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    logic [31:0] a, b, h, l;
    logic [63:0] acc;
    n_mismatch = 0;
    samples_checked = 0;
    lfsr = 32'h03d6d5bd;
    presetn = 1'b0;
    clk_en = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`MSX_A_ACC_HI, 32'h0);
    rd(`MSX_A_FIR, 32'h1);
    rd(12'h03c, 32'h0, 1'b1);
    wr(12'h100, 32'hffffffff, 1'b1);
    wr(`MSX_A_STATUS, 32'hffffffff);
    rd(`MSX_A_STATUS, 32'h0);
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 32'hffffffff : rnd();
      b = (i == 0) ? 32'hffffffff : rnd();
      h = rnd();
      l = rnd();
      wr(`MSX_A_ACC_LO, l);
      mv(4'h8, 5'h0, h);
      rd(`MSX_A_ACC_HI, h);
      wr(`MSX_A_OPB, b);
      mv(4'h2, 5'h0, a);
      acc = {h, l} - {32'h0, a} * {32'h0, b};
      rd(`MSX_A_ACC_HI, acc[63:32]);
      rd(`MSX_A_ACC_LO, acc[31:0]);
      rd(`MSX_A_STATUS, 32'h0);
    end
    // mid-run reset with the bus idle, then a frozen stretch
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    clk_en <= 1'b1;
    rd(`MSX_A_ACC_HI, 32'h0);
    rd(`MSX_A_ACC_LO, 32'h0);
    wr(`MSX_A_CTRL, 32'hf);
    a = rnd();
    b = rnd();
    cmd(4'h3, 2'h0, 5'h0, 5'h07, 5'h0, 5'h0, 3'h2, a);
    wr(`MSX_A_SEL, 32'h47);
    rd(`MSX_A_CP0, a);
    ld(5'h05, a, b);
    wr(`MSX_A_SEL, 32'h5);
    rd(`MSX_A_FPR_LO, a);
    rd(`MSX_A_FPR_HI, b);
    mv(4'h5, 5'h03, b);
    mv(4'h7, 5'h03, a);
    wr(`MSX_A_SEL, 32'h3);
    rd(`MSX_A_CP2_LO, b);
    rd(`MSX_A_CP2_HI, a);
    wr(`MSX_A_CTRL, 32'h8);
    mv(4'h4, 5'h05, ~a);
    wr(`MSX_A_SEL, 32'h5);
    rd(`MSX_A_FPR_LO, a);
    rd(`MSX_A_STATUS, 32'h1);
    // low lane picked so that rounding the product first cancels to zero; high lane gives 5
    wr(`MSX_A_CTRL, 32'ha);
    ld(5'h01, 32'h3f800001, 32'h40000000);
    ld(5'h02, 32'h3f800001, 32'h40400000);
    ld(5'h03, 32'h3f800002, 32'h3f800000);
    wr(`MSX_A_FP_CONTROL_STATUS, 32'h0);
    cmd(4'h1, 2'h0, 5'h04, 5'h01, 5'h02, 5'h03, 3'h0, 32'h0);
    wr(`MSX_A_SEL, 32'h4);
    rd(`MSX_A_FPR_LO, 32'h0);
    rd(`MSX_A_FP_CONTROL_STATUS, 32'h1004);
    rd(`MSX_A_STATUS, 32'h0);
    cmd(4'h1, 2'h2, 5'h06, 5'h01, 5'h02, 5'h03, 3'h0, 32'h0);
    wr(`MSX_A_SEL, 32'h6);
    rd(`MSX_A_FPR_LO, 32'h0);
    rd(`MSX_A_FPR_HI, 32'h40a00000);
    rd(`MSX_A_FP_CONTROL_STATUS, 32'h1004);
    wr(`MSX_A_FP_CONTROL_STATUS, 32'h100000);
    cmd(4'h1, 2'h0, 5'h04, 5'h01, 5'h02, 5'h03, 3'h0, 32'h0);
    wr(`MSX_A_SEL, 32'h4);
    rd(`MSX_A_FPR_LO, 32'h28800000);
    rd(`MSX_A_FPR_HI, 32'h0);
    rd(`MSX_A_FP_CONTROL_STATUS, 32'h100000);
    // inexact enabled: the unfused run traps, fd and flags stay
    wr(`MSX_A_FP_CONTROL_STATUS, 32'h80);
    cmd(4'h1, 2'h0, 5'h04, 5'h01, 5'h02, 5'h03, 3'h0, 32'h0);
    rd(`MSX_A_STATUS, 32'h4);
    rd(`MSX_A_FP_CONTROL_STATUS, 32'h1080);
    cmd(4'h1, 2'h3, 5'h04, 5'h01, 5'h02, 5'h03, 3'h0, 32'h0);
    rd(`MSX_A_STATUS, 32'h2);
    rd(`MSX_A_FPR_LO, 32'h28800000);
    // let the last answer be compared before the verdict
    repeat (2) @(posedge pclk);
    finish_test();
  end
endmodule
bind msx_exec msx_exec_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
